// ===== testbench/mhf_host_fifo_bench.sv
`timescale 1ns/1ps
`include "mhf_map.svh"
module mhf_host_fifo_bench;
   import mhf_pkg::*;
   logic ref_clk, arst_n, tx_queue_enable, dma_request_enable, transition_coding_enable;
   mhf_pkg::mhf_mode_t mode;
   mhf_pkg::mhf_crc_t  crc_select;
   logic aux_channel_enable, fast_trellis_mode, aux_rate_load, prbs_test_enable;
   logic caller_id_mode, host_tx_write, host_rx_read, line_tx_take, line_rx_valid;
   logic line_bit_strobe, line_rx_level, ring_raw, data_set_ready_raw, hook_cmd, talk_cmd;
   logic pulse_dial_enable, pulse_dial_break, line_tx_valid, tx_half_full_flag;
   logic rx_half_full_flag, tx_not_empty_flag, rx_not_empty_flag, tx_buffer_empty_irq;
   logic rx_buffer_full_irq, irq, ring_indicator_out, data_set_ready_out, line_tx_level;
   logic line_rx_bit, caller_id_serial, prbs_error, aux_channel_active, hook_relay_drive;
   logic talk_relay_drive;
   logic [3:0]  irq_mask;
   logic [7:0]  host_tx_data, line_rx_data, rx_data_register, line_tx_data;
   logic [15:0] aux_rate_in, aux_rate;
   logic [31:0] crc_poly, crc_init;
   int mismatches, cmp_count, irq_cnt, n;
   mhf_host_fifo mhf_host_fifo_i (.ref_clk, .arst_n, .mode, .crc_select, .tx_queue_enable,
      .dma_request_enable, .transition_coding_enable, .aux_channel_enable, .fast_trellis_mode,
      .aux_rate_in, .aux_rate_load, .prbs_test_enable, .caller_id_mode, .irq_mask,
      .host_tx_write, .host_tx_data, .host_rx_read, .line_tx_take, .line_rx_valid,
      .line_rx_data, .line_bit_strobe, .line_rx_level, .ring_raw, .data_set_ready_raw,
      .hook_cmd, .talk_cmd, .pulse_dial_enable, .pulse_dial_break, .rx_data_register,
      .line_tx_data, .line_tx_valid, .tx_half_full_flag, .rx_half_full_flag,
      .tx_not_empty_flag, .rx_not_empty_flag, .tx_buffer_empty_irq, .rx_buffer_full_irq, .irq,
      .ring_indicator_out, .data_set_ready_out, .line_tx_level, .line_rx_bit,
      .caller_id_serial, .prbs_error, .crc_poly, .crc_init, .aux_channel_active, .aux_rate,
      .hook_relay_drive, .talk_relay_drive);
   mhf_line_model line_m (.ref_clk, .line_tx_valid, .line_tx_data, .line_tx_take,
      .line_rx_valid, .line_rx_data);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (irq === 1'b1) irq_cnt++;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #2;
   endtask : tick
   task automatic tx_burst(input int k, input logic [7:0] base);
      host_tx_write = 1'b1;
      for (int i = 0; i < k; i++) begin
         host_tx_data = base + 8'(i);
         tick(1);
      end
      host_tx_write = 1'b0;
   endtask : tx_burst
   task automatic rx_read();
      host_rx_read = 1'b1;
      tick(1);
      host_rx_read = 1'b0;
   endtask : rx_read
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (4000) @(posedge ref_clk);
      mismatches++;
      end_of_test();
   end
   initial begin
      {arst_n, tx_queue_enable, dma_request_enable, transition_coding_enable} = '0;
      {aux_channel_enable, fast_trellis_mode, aux_rate_load, prbs_test_enable} = '0;
      {caller_id_mode, host_tx_write, host_rx_read, line_bit_strobe, line_rx_level} = '0;
      {ring_raw, data_set_ready_raw, hook_cmd, talk_cmd, pulse_dial_enable} = '0;
      {pulse_dial_break, irq_mask, host_tx_data, aux_rate_in} = '0;
      mode = MHF_MODE_HDLC;
      crc_select = MHF_CRC_16;
      tx_queue_enable = 1'b1;
      tick(10);
      arst_n = 1'b1;
      tick(3);
      check(aux_rate, 16'h0096);
      check(crc_poly, `MHF_CRC16_POLY);
      irq_mask = 4'b1111;
      dma_request_enable = 1'b1;
      ring_raw = 1'b1;
      irq_cnt = 0;
      tx_burst(9, 8'h10);
      tick(2);
      check({tx_half_full_flag, tx_not_empty_flag}, 2'b11);
      check(ring_indicator_out, 1'b0);
      check(irq_cnt, 2);
      line_m.take(4);
      tick(2);
      check(tx_half_full_flag, 1'b1);
      line_m.take(1);
      tick(2);
      check({tx_half_full_flag, ring_indicator_out}, 2'b01);
      line_m.take(3);
      tick(2);
      line_m.take(1);
      tick(2);
      check(tx_not_empty_flag, 1'b0);
      check(irq_cnt, 4);
      check(line_m.got.size(), 8);
      for (int i = 0; i < 8; i++) check(line_m.got[i], 8'h10 + 8'(i));
      irq_mask = 4'b0000;
      tx_burst(1, 8'h55);
      tick(2);
      line_m.take(1);
      tick(3);
      check(irq_cnt, 4);
      tx_queue_enable = 1'b0;
      n = line_m.got.size();
      tx_burst(2, 8'hA0);
      tick(2);
      check(tx_half_full_flag, 1'b0);
      line_m.take(1);
      tick(2);
      line_m.take(1);
      tick(2);
      check(line_m.got.size(), n + 1);
      check(line_m.got[n], 8'hA0);
      line_m.push(5, 8'h40);
      tick(2);
      check({rx_half_full_flag, rx_not_empty_flag, data_set_ready_out}, 3'b111);
      for (int i = 0; i < 5; i++) begin
         check(rx_data_register, 8'h40 + 8'(i));
         rx_read();
         tick(1);
      end
      tick(2);
      check({rx_not_empty_flag, data_set_ready_out}, 2'b00);
      dma_request_enable = 1'b0;
      ring_raw = 1'b0;
      data_set_ready_raw = 1'b1;
      tick(3);
      check({ring_indicator_out, data_set_ready_out}, 2'b01);
      for (int m = 0; m < 3; m++) begin
         mode = mhf_mode_t'(m);
         dma_request_enable = ~dma_request_enable;
         tick(3);
         check(ring_indicator_out, dma_request_enable);
      end
      mode = MHF_MODE_HDLC;
      crc_select = MHF_CRC_32;
      tick(3);
      check(crc_poly, `MHF_CRC32_POLY);
      check(crc_init, `MHF_CRC32_INIT);
      aux_rate_in = 16'h012C;
      aux_rate_load = 1'b1;
      tick(1);
      aux_rate_load = 1'b0;
      tick(2);
      check(aux_rate, 16'h012C);
      {hook_cmd, pulse_dial_enable, pulse_dial_break} = 3'b111;
      {aux_channel_enable, fast_trellis_mode, caller_id_mode} = 3'b111;
      line_rx_level = 1'b0;
      line_bit_strobe = 1'b1;
      tick(1);
      line_bit_strobe = 1'b0;
      tick(2);
      check({hook_relay_drive, talk_relay_drive}, 2'b11);
      check(aux_channel_active, 1'b1);
      check(line_rx_bit, 1'b0);
      check(caller_id_serial, 1'b0);
      end_of_test();
   end
endmodule : mhf_host_fifo_bench

// ===== testbench/mhf_host_fifo_properties.sv
`timescale 1ns/1ps
`include "mhf_map.svh"
module mhf_host_fifo_properties
   import mhf_pkg::*;
(
   input wire logic               ref_clk,
   input wire logic               arst_n,
   input wire mhf_pkg::mhf_mode_t mode,
   input wire mhf_pkg::mhf_crc_t  crc_select,
   input wire logic               dma_request_enable,
   input wire logic               ring_raw,
   input wire logic [15:0]        aux_rate_in,
   input wire logic               aux_rate_load,
   input wire logic               tx_half_full_flag,
   input wire logic               rx_half_full_flag,
   input wire logic               tx_not_empty_flag,
   input wire logic               rx_not_empty_flag,
   input wire logic               tx_buffer_empty_irq,
   input wire logic               rx_buffer_full_irq,
   input wire logic               irq,
   input wire logic [3:0]         irq_mask,
   input wire logic               ring_indicator_out,
   input wire logic               data_set_ready_out,
   input wire logic               line_tx_valid,
   input wire logic [31:0]        crc_poly,
   input wire logic [15:0]        aux_rate
);
   import mhf_pkg::*;
   logic [1:0] up_r;
   logic [1:0] up_nxt;
   logic       live;
   logic [3:0] fl;
   assign live = (up_r == 2'd3);
   assign fl   = {rx_not_empty_flag, tx_not_empty_flag, rx_half_full_flag, tx_half_full_flag};
   // counts edges since reset release, holding at three
   always_comb begin
      up_nxt = (up_r == 2'd3) ? up_r : up_r + 2'd1;
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) up_r <= 2'd0;
      else up_r <= up_nxt;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence dma_on_held;
      live && dma_request_enable && $past(dma_request_enable);
   endsequence
   sequence dma_off_held;
      live && !dma_request_enable && !$past(dma_request_enable);
   endsequence
   tx_half_ne_a: assert property (tx_half_full_flag |-> tx_not_empty_flag)
      else $error("tx half full without not empty");
   rx_half_ne_a: assert property (rx_half_full_flag |-> rx_not_empty_flag)
      else $error("rx half full without not empty");
   tx_valid_flag_a: assert property (line_tx_valid == tx_not_empty_flag)
      else $error("tx valid disagrees with not empty");
   irq_cause_a: assert property (live && irq |->
      (|((fl ^ $past(fl)) & irq_mask)) || (|(($past(fl) ^ $past(fl, 2)) & irq_mask)))
      else $error("irq without masked flag change");
   tx_dma_pin_a: assert property (dma_on_held ##0 $stable(tx_buffer_empty_irq)
      |-> ring_indicator_out == tx_buffer_empty_irq)
      else $error("tx request pin wrong");
   rx_dma_pin_a: assert property (dma_on_held ##0 $stable(rx_buffer_full_irq)
      |-> data_set_ready_out == rx_buffer_full_irq)
      else $error("rx request pin wrong");
   ring_raw_a: assert property (dma_off_held ##0 $stable(ring_raw)
      |-> ring_indicator_out == ring_raw)
      else $error("ring pin not raw with dma off");
   crc_wide_a: assert property (live && $past(mode) == MHF_MODE_HDLC
      && $past(crc_select) == MHF_CRC_32 |-> crc_poly == `MHF_CRC32_POLY)
      else $error("crc32 polynomial wrong");
   crc_narrow_a: assert property (live && $past(mode) == MHF_MODE_HDLC
      && $past(crc_select) == MHF_CRC_16 |-> crc_poly == `MHF_CRC16_POLY)
      else $error("crc16 polynomial wrong");
   aux_load_a: assert property (live && $past(aux_rate_load) |-> aux_rate == $past(aux_rate_in))
      else $error("aux rate not loaded");
endmodule : mhf_host_fifo_properties
bind mhf_host_fifo mhf_host_fifo_properties mhf_host_fifo_properties_i (.ref_clk, .arst_n,
   .mode, .crc_select, .dma_request_enable, .ring_raw, .aux_rate_in, .aux_rate_load,
   .tx_half_full_flag, .rx_half_full_flag, .tx_not_empty_flag, .rx_not_empty_flag,
   .tx_buffer_empty_irq, .rx_buffer_full_irq, .irq, .irq_mask, .ring_indicator_out,
   .data_set_ready_out, .line_tx_valid, .crc_poly, .aux_rate);

// ===== testbench/mhf_line_model.sv
`timescale 1ns/1ps
module mhf_line_model (
   input  wire logic       ref_clk,
   input  wire logic       line_tx_valid,
   input  wire logic [7:0] line_tx_data,
   output logic            line_tx_take,
   output logic            line_rx_valid,
   output logic [7:0]      line_rx_data
);
   logic [7:0] got[$];
   initial begin
      line_tx_take = 1'b0;
      line_rx_valid = 1'b0;
      line_rx_data = 8'h00;
   end
   // pops n bytes, recording the head while valid
   task automatic take(input int n);
      line_tx_take = 1'b1;
      repeat (n) begin
         if (line_tx_valid === 1'b1) got.push_back(line_tx_data);
         @(posedge ref_clk);
         #2;
      end
      line_tx_take = 1'b0;
   endtask : take
   // pushes n counting bytes, then scrambles the idle data lines
   task automatic push(input int n, input logic [7:0] base);
      line_rx_valid = 1'b1;
      for (int i = 0; i < n; i++) begin
         line_rx_data = base + 8'(i);
         @(posedge ref_clk);
         #2;
      end
      line_rx_valid = 1'b0;
      line_rx_data = ~line_rx_data;
   endtask : push
endmodule : mhf_line_model

// ===== verilog/mhf_byte_fifo.sv
`timescale 1ns/1ps
`include "mhf_map.svh"
module mhf_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `MHF_FIFO_DEPTH,
   parameter int CW    = `MHF_CNT_W
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [CW-1:0]    cap,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] rdata,
   output logic      [CW-1:0]    count,
   output logic                  full
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || CW <= AW)
         $error("mhf_byte_fifo: bad depth or count width");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [CW-1:0]    cnt_r, cnt_nxt;
   logic [WIDTH-1:0] rd_r, rd_nxt;
   logic             do_push, do_pop;
   always_comb begin
      do_push = push && (cnt_r < cap);
      do_pop  = pop && (cnt_r != '0);
      wp_nxt  = do_push ? wp_r + 1'b1 : wp_r;
      rp_nxt  = do_pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + CW'(do_push) - CW'(do_pop);
      if (cnt_nxt == '0)
         rd_nxt = '0;
      else if (cnt_r == '0 || (do_pop && cnt_r == CW'(1)))
         rd_nxt = wdata;
      else
         rd_nxt = do_pop ? mem_r[rp_nxt] : mem_r[rp_r];
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
         rd_r  <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
         rd_r  <= rd_nxt;
      end
   end
   always_ff @(posedge clk) begin
      if (do_push)
         mem_r[wp_r] <= wdata;
   end
   assign rdata = rd_r;
   assign count = cnt_r;
   assign full  = (cnt_r >= cap);
endmodule : mhf_byte_fifo

// ===== verilog/mhf_host_fifo.sv
`timescale 1ns/1ps
`include "mhf_map.svh"
// Function
// - separate eight-byte transmit and receive queues
// - receive queue always active
// - transmit queue eight bytes when enable set, one byte when clear
// - half-full flag at four or more bytes
// - not-empty flag with any byte held
// - interrupt on any flag change, masked
// - dma gated by enable in every mode
// - ring and ready pins become dma requests
// - requests follow empty and full interrupt bits
// - transition coding in sync/hdlc when enabled
// - plain coding: one high, zero low
// - transition coding: zero toggles, one holds
// - crc16 default, crc32 when selected
// - aux channel in fast modes when enabled
// - aux rate defaults 150, host programmable
// - 511 pattern generate and check in sync
// - caller id serial and via receive buffer
// - drive hook and talk relays, pulse dial
// - irq only for enabled conditions
module mhf_host_fifo
   import mhf_pkg::*;
#(
   parameter int DEPTH = `MHF_FIFO_DEPTH
) (
   input  wire logic              ref_clk,
   input  wire logic              arst_n,
   input  wire mhf_pkg::mhf_mode_t mode,
   input  wire mhf_pkg::mhf_crc_t  crc_select,
   input  wire logic              tx_queue_enable,
   input  wire logic              dma_request_enable,
   input  wire logic              transition_coding_enable,
   input  wire logic              aux_channel_enable,
   input  wire logic              fast_trellis_mode,
   input  wire logic [15:0]       aux_rate_in,
   input  wire logic              aux_rate_load,
   input  wire logic              prbs_test_enable,
   input  wire logic              caller_id_mode,
   input  wire logic [3:0]        irq_mask,
   input  wire logic              host_tx_write,
   input  wire logic [7:0]        host_tx_data,
   input  wire logic              host_rx_read,
   input  wire logic              line_tx_take,
   input  wire logic              line_rx_valid,
   input  wire logic [7:0]        line_rx_data,
   input  wire logic              line_bit_strobe,
   input  wire logic              line_rx_level,
   input  wire logic              ring_raw,
   input  wire logic              data_set_ready_raw,
   input  wire logic              hook_cmd,
   input  wire logic              talk_cmd,
   input  wire logic              pulse_dial_enable,
   input  wire logic              pulse_dial_break,
   output logic [7:0]             rx_data_register,
   output logic [7:0]             line_tx_data,
   output logic                   line_tx_valid,
   output logic                   tx_half_full_flag,
   output logic                   rx_half_full_flag,
   output logic                   tx_not_empty_flag,
   output logic                   rx_not_empty_flag,
   output logic                   tx_buffer_empty_irq,
   output logic                   rx_buffer_full_irq,
   output logic                   irq,
   output logic                   ring_indicator_out,
   output logic                   data_set_ready_out,
   output logic                   line_tx_level,
   output logic                   line_rx_bit,
   output logic                   caller_id_serial,
   output logic                   prbs_error,
   output logic [31:0]            crc_poly,
   output logic [31:0]            crc_init,
   output logic                   aux_channel_active,
   output logic [15:0]            aux_rate,
   output logic                   hook_relay_drive,
   output logic                   talk_relay_drive
);
   import mhf_pkg::*;
   localparam int CW = `MHF_CNT_W;
   initial begin
      if (DEPTH != (1 << (CW - 1)))
         $error("mhf_host_fifo: depth must match count width");
   end

   logic rs1_r, rst_n;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rs1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rst_n <= rs1_r;
      end
   end

   logic [CW-1:0] tx_cap, tx_cnt, rx_cnt;
   logic [7:0]    tx_q, rx_q;
   logic          tx_full, rx_full;
   assign tx_cap = tx_queue_enable ? CW'(DEPTH) : CW'(1);

   // transmit and receive queues
   mhf_byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .cap   (tx_cap),
      .push  (host_tx_write),
      .wdata (host_tx_data),
      .pop   (line_tx_take),
      .rdata (tx_q),
      .count (tx_cnt),
      .full  (tx_full)
   );
   mhf_byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_rx (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .cap   (CW'(DEPTH)),
      .push  (line_rx_valid),
      .wdata (line_rx_data),
      .pop   (host_rx_read),
      .rdata (rx_q),
      .count (rx_cnt),
      .full  (rx_full)
   );

   // flags, interrupts, dma
   logic [3:0] flag_cur, flag_prev_r, flag_prev_nxt;
   logic       irq_r, irq_nxt, txe_r, txe_nxt, rxf_r, rxf_nxt;
   logic       ring_r, ring_nxt, dsr_r, dsr_nxt, dma_ok;
   always_comb begin
      flag_cur[0]   = (tx_cnt >= CW'(`MHF_HALF_LEVEL));
      flag_cur[1]   = (rx_cnt >= CW'(`MHF_HALF_LEVEL));
      flag_cur[2]   = (tx_cnt != '0);
      flag_cur[3]   = (rx_cnt != '0);
      flag_prev_nxt = flag_cur;
      irq_nxt       = |((flag_cur ^ flag_prev_r) & irq_mask);
      txe_nxt       = !tx_full;
      rxf_nxt       = rx_cnt != '0;
      dma_ok        = dma_request_enable && (mode == MHF_MODE_ASYNC ||
                      mode == MHF_MODE_SYNC || mode == MHF_MODE_HDLC);
      ring_nxt      = dma_ok ? txe_nxt : ring_raw;
      dsr_nxt       = dma_ok ? rxf_nxt : data_set_ready_raw;
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_prev_r <= '0;
         irq_r       <= 1'b0;
         txe_r       <= 1'b0;
         rxf_r       <= 1'b0;
         ring_r      <= 1'b0;
         dsr_r       <= 1'b0;
      end else begin
         flag_prev_r <= flag_prev_nxt;
         irq_r       <= irq_nxt;
         txe_r       <= txe_nxt;
         rxf_r       <= rxf_nxt;
         ring_r      <= ring_nxt;
         dsr_r       <= dsr_nxt;
      end
   end

   // line coding, prbs, caller id
   logic       sync_like, nrzi_on;
   logic       txl_r, txl_nxt, rxp_r, rxp_nxt, rxb_r, rxb_nxt;
   logic       cid_r, cid_nxt, perr_r, perr_nxt;
   logic [8:0] pg_r, pg_nxt, pc_r, pc_nxt;
   logic [2:0] bi_r, bi_nxt;
   logic       data_bit, pg_bit, rx_dec;
   always_comb begin
      sync_like = (mode == MHF_MODE_SYNC) || (mode == MHF_MODE_HDLC);
      nrzi_on   = sync_like && transition_coding_enable;
      pg_bit    = pg_r[8] ^ pg_r[`MHF_PRBS_TAP];
      data_bit  = (prbs_test_enable && mode == MHF_MODE_SYNC) ? pg_bit : tx_q[bi_r];
      txl_nxt   = txl_r;
      rxp_nxt   = rxp_r;
      rxb_nxt   = rxb_r;
      pg_nxt    = pg_r;
      pc_nxt    = pc_r;
      perr_nxt  = perr_r;
      bi_nxt    = bi_r;
      rx_dec    = nrzi_on ? (line_rx_level == rxp_r) : line_rx_level;
      if (line_bit_strobe) begin
         txl_nxt = nrzi_on ? (data_bit ? txl_r : !txl_r) : data_bit;
         bi_nxt  = bi_r + 3'd1;
         rxp_nxt = line_rx_level;
         rxb_nxt = rx_dec;
         if (prbs_test_enable && mode == MHF_MODE_SYNC) begin
            pg_nxt   = {pg_r[7:0], pg_bit};
            pc_nxt   = {pc_r[7:0], rx_dec};
            perr_nxt = rx_dec != (pc_r[8] ^ pc_r[`MHF_PRBS_TAP]);
         end
      end
      cid_nxt = caller_id_mode ? rxb_r : 1'b1;
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txl_r  <= 1'b1;
         rxp_r  <= 1'b1;
         rxb_r  <= 1'b1;
         cid_r  <= 1'b1;
         perr_r <= 1'b0;
         pg_r   <= `MHF_PRBS_SEED;
         pc_r   <= `MHF_PRBS_SEED;
         bi_r   <= '0;
      end else begin
         txl_r  <= txl_nxt;
         rxp_r  <= rxp_nxt;
         rxb_r  <= rxb_nxt;
         cid_r  <= cid_nxt;
         perr_r <= perr_nxt;
         pg_r   <= pg_nxt;
         pc_r   <= pc_nxt;
         bi_r   <= bi_nxt;
      end
   end

   // crc, aux channel, relays
   logic [31:0] poly_r, poly_nxt, init_r, init_nxt;
   logic [15:0] rate_r, rate_nxt;
   logic        aux_r, aux_nxt, hook_r, hook_nxt, talk_r, talk_nxt;
   always_comb begin
      poly_nxt = (crc_select == MHF_CRC_32) ? `MHF_CRC32_POLY : `MHF_CRC16_POLY;
      init_nxt = (crc_select == MHF_CRC_32) ? `MHF_CRC32_INIT : `MHF_CRC16_INIT;
      aux_nxt  = aux_channel_enable && fast_trellis_mode;
      rate_nxt = aux_rate_load ? aux_rate_in : rate_r;
      hook_nxt = hook_cmd;
      talk_nxt = pulse_dial_enable ? pulse_dial_break : talk_cmd;
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         poly_r <= `MHF_CRC16_POLY;
         init_r <= `MHF_CRC16_INIT;
         aux_r  <= 1'b0;
         rate_r <= `MHF_AUX_RATE_RST;
         hook_r <= 1'b0;
         talk_r <= 1'b0;
      end else begin
         poly_r <= poly_nxt;
         init_r <= init_nxt;
         aux_r  <= aux_nxt;
         rate_r <= rate_nxt;
         hook_r <= hook_nxt;
         talk_r <= talk_nxt;
      end
   end

   assign rx_data_register    = rx_q;
   assign line_tx_data        = tx_q;
   assign line_tx_valid       = flag_prev_r[2];
   assign tx_half_full_flag   = flag_prev_r[0];
   assign rx_half_full_flag   = flag_prev_r[1];
   assign tx_not_empty_flag   = flag_prev_r[2];
   assign rx_not_empty_flag   = flag_prev_r[3];
   assign tx_buffer_empty_irq = txe_r;
   assign rx_buffer_full_irq  = rxf_r;
   assign irq                 = irq_r;
   assign ring_indicator_out  = ring_r;
   assign data_set_ready_out  = dsr_r;
   assign line_tx_level       = txl_r;
   assign line_rx_bit         = rxb_r;
   assign caller_id_serial    = cid_r;
   assign prbs_error          = perr_r;
   assign crc_poly            = poly_r;
   assign crc_init            = init_r;
   assign aux_channel_active  = aux_r;
   assign aux_rate            = rate_r;
   assign hook_relay_drive    = hook_r;
   assign talk_relay_drive    = talk_r;
endmodule : mhf_host_fifo

// ===== verilog/mhf_map.svh
`ifndef MHF_MAP_SVH
`define MHF_MAP_SVH
`define MHF_FIFO_DEPTH      8
`define MHF_HALF_LEVEL      4
`define MHF_CNT_W           4
`define MHF_AUX_RATE_RST    16'h0096
`define MHF_PRBS_SEED       9'h1_FF
`define MHF_PRBS_TAP        4
`define MHF_CRC16_POLY      32'h0000_1021
`define MHF_CRC32_POLY      32'h04C1_1DB7
`define MHF_CRC16_INIT      32'h0000_FFFF
`define MHF_CRC32_INIT      32'hFFFF_FFFF
`endif

// ===== verilog/mhf_pkg.sv
package mhf_pkg;
   typedef enum logic [1:0] {
      MHF_MODE_ASYNC,
      MHF_MODE_SYNC,
      MHF_MODE_HDLC
   } mhf_mode_t;
   typedef enum logic {
      MHF_CRC_16,
      MHF_CRC_32
   } mhf_crc_t;
endpackage : mhf_pkg
